// ---- logic/cef_pkg.sv ----
// Shared constants and carrier types for the charger event flag bank
package cef_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_LATCH_C = 8'h24;
  localparam logic [7:0] ADDR_LATCH_D = 8'h25;
  localparam logic [7:0] ADDR_LATCH_A = 8'h26;
  localparam logic [7:0] ADDR_LATCH_B = 8'h27;
  localparam logic [7:0] ADDR_GATE_A  = 8'h28;
  localparam logic [7:0] RESET_VAL    = 8'h00;
  localparam logic [7:0] READ_NONE    = 8'h00;
  localparam int         NUM_LATCH    = 4;

  // Latch registers in index order c, d, a, b
  localparam logic [7:0] LATCH_ADDR [NUM_LATCH] =
    '{8'h24, 8'h25, 8'h26, 8'h27};
  // Implemented bits; reserved bits stay zero
  localparam logic [7:0] LATCH_USED [NUM_LATCH] =
    '{8'h7F, 8'h1F, 8'hFF, 8'hF4};
  // Bits that latch on both edges of their source level
  localparam logic [7:0] LATCH_BOTH [NUM_LATCH] =
    '{8'h10, 8'h0F, 8'h80, 8'h00};

  // ****************************************************************
  // Interrupt gate field positions
  // ****************************************************************
  localparam int GATE_INPUT_CURRENT = 7;
  localparam int GATE_INPUT_VOLTAGE = 6;
  localparam int GATE_WATCHDOG      = 5;
  localparam int GATE_WEAK_SOURCE   = 4;
  localparam int GATE_POWER_GOOD    = 3;
  localparam int GATE_INPUT_TWO     = 2;
  localparam int GATE_INPUT_ONE     = 1;
  localparam int GATE_BUS_PRESENT   = 0;
  // Gate sources that fire on any change rather than a rising edge
  localparam logic [7:0] GATE_BOTH  = 8'h0F;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ       = 40_000_000;
  localparam longint IRQ_PULSE_US = 100;
  localparam longint IRQ_PULSE_CYC_L =
    (IRQ_PULSE_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;
  localparam logic [11:0] IRQ_PULSE_CYC = IRQ_PULSE_CYC_L[11:0];

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic port_detect_finished;
    logic conversion_done;
    logic minimum_system_voltage;
    logic fast_charge_timeout;
    logic trickle_timeout;
    logic precharge_timeout;
    logic topoff_timeout;
    logic battery_low_for_otg;
    logic thermistor_cold;
    logic thermistor_cool;
    logic thermistor_warm;
    logic thermistor_hot;
    logic battery_current_reg;
    logic bus_overvoltage;
    logic battery_overvoltage;
    logic input_overcurrent;
    logic discharge_overcurrent;
    logic converter_overcurrent;
    logic input_two_overvoltage;
    logic input_one_overvoltage;
    logic system_short;
    logic system_overvoltage;
    logic otg_overvoltage;
    logic otg_undervoltage;
    logic thermal_shutdown;
  } cef_det_t;

  typedef struct packed {
    logic input_current_limiting;
    logic otg_current_limiting;
    logic input_voltage_limiting;
    logic otg_voltage_regulation;
    logic watchdog_expired;
    logic weak_source;
    logic power_good;
    logic input_two_present;
    logic input_one_present;
    logic bus_present;
  } cef_src_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cef_req_t;

endpackage

// ---- logic/cef_flag_bank.sv ----
// Charger event flag registers, interrupt gate register and pulse driver
`timescale 1ns/1ps
`default_nettype none

module cef_flag_bank #(
  parameter logic [11:0] PULSE_CYCLES = cef_pkg::IRQ_PULSE_CYC
) (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic            reg_reset_req,
  // Register access port
  input  wire cef_pkg::cef_req_t req,
  output logic [7:0]           rd_data,
  output logic                 rd_valid,
  // Event sources from detectors
  input  wire cef_pkg::cef_det_t det,
  input  wire logic            one_shot_mode,
  input  wire cef_pkg::cef_src_t src,
  // Open-drain interrupt pin
  input  wire logic            irq_out_n_in,
  output logic                 irq_out_n_out,
  output logic                 irq_out_n_oe_n,
  // Pin level observed back, for status
  output logic                 irq_pin_low
);

  // ****************************************************************
  // Source levels grouped per latch register
  // ****************************************************************
  logic [7:0] lvl [cef_pkg::NUM_LATCH];
  logic [7:0] flag_q [cef_pkg::NUM_LATCH];

  // Bit order follows each register's field layout
  always_comb begin
    lvl[0] = {1'b0,
              det.port_detect_finished,
              det.conversion_done & one_shot_mode,
              det.minimum_system_voltage,
              det.fast_charge_timeout,
              det.trickle_timeout,
              det.precharge_timeout,
              det.topoff_timeout};
    lvl[1] = {3'b000,
              det.battery_low_for_otg,
              det.thermistor_cold,
              det.thermistor_cool,
              det.thermistor_warm,
              det.thermistor_hot};
    lvl[2] = {det.battery_current_reg,
              det.bus_overvoltage,
              det.battery_overvoltage,
              det.input_overcurrent,
              det.discharge_overcurrent,
              det.converter_overcurrent,
              det.input_two_overvoltage,
              det.input_one_overvoltage};
    lvl[3] = {det.system_short,
              det.system_overvoltage,
              det.otg_overvoltage,
              det.otg_undervoltage,
              1'b0,
              det.thermal_shutdown,
              2'b00};
  end

  // ****************************************************************
  // Latch registers, one per generate entry
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < cef_pkg::NUM_LATCH; gi++) begin : g_latch
      logic [7:0] prev_q;
      logic [7:0] prev_d;
      logic [7:0] flg_d;
      logic [7:0] hit;
      logic       clr;

      // Edge detect and clear-on-read; a new event beats the clear
      always_comb begin
        hit    = (lvl[gi] & ~prev_q)
               | (cef_pkg::LATCH_BOTH[gi] & ~lvl[gi] & prev_q);
        clr    = req.rd && (req.addr == cef_pkg::LATCH_ADDR[gi]);
        prev_d = lvl[gi];
        flg_d  = ((clr ? 8'h00 : flag_q[gi]) | hit)
               & cef_pkg::LATCH_USED[gi];
      end

      // Level history starts from reset value so a level already high
      // at release counts as an event
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          prev_q     <= cef_pkg::RESET_VAL;
          flag_q[gi] <= cef_pkg::RESET_VAL;
        end else begin
          prev_q     <= prev_d;
          flag_q[gi] <= flg_d;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Interrupt gate register
  // ****************************************************************
  logic [7:0] gate_q;
  logic [7:0] gate_d;

  // Register reset request wins over a write in the same cycle
  always_comb begin
    gate_d = gate_q;
    if (reg_reset_req) begin
      gate_d = cef_pkg::RESET_VAL;
    end else if (req.wr && (req.addr == cef_pkg::ADDR_GATE_A)) begin
      gate_d = req.wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= cef_pkg::RESET_VAL;
    end else begin
      gate_q <= gate_d;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] rdat_q;
  logic [7:0] rdat_d;
  logic       rval_q;
  logic       rval_d;

  // Unmapped addresses read as zero; flag writes have no effect
  always_comb begin
    rval_d = req.rd;
    rdat_d = rdat_q;
    if (req.rd) begin
      unique case (req.addr)
        cef_pkg::ADDR_LATCH_C: rdat_d = flag_q[0];
        cef_pkg::ADDR_LATCH_D: rdat_d = flag_q[1];
        cef_pkg::ADDR_LATCH_A: rdat_d = flag_q[2];
        cef_pkg::ADDR_LATCH_B: rdat_d = flag_q[3];
        cef_pkg::ADDR_GATE_A:  rdat_d = gate_q;
        default:               rdat_d = cef_pkg::READ_NONE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdat_q <= cef_pkg::READ_NONE;
      rval_q <= 1'b0;
    end else begin
      rdat_q <= rdat_d;
      rval_q <= rval_d;
    end
  end

  assign rd_data  = rdat_q;
  assign rd_valid = rval_q;

  // ****************************************************************
  // Interrupt sources and gating
  // ****************************************************************
  logic [7:0] ilvl;
  logic [7:0] iprev_q;
  logic [7:0] iprev_d;
  logic [7:0] ievt;
  logic       irq_fire;

  // Shared sources are ORed so either party's regulation counts
  always_comb begin
    ilvl = '0;
    ilvl[cef_pkg::GATE_INPUT_CURRENT] = src.input_current_limiting
                                      | src.otg_current_limiting;
    ilvl[cef_pkg::GATE_INPUT_VOLTAGE] = src.input_voltage_limiting
                                      | src.otg_voltage_regulation;
    ilvl[cef_pkg::GATE_WATCHDOG]      = src.watchdog_expired;
    ilvl[cef_pkg::GATE_WEAK_SOURCE]   = src.weak_source;
    ilvl[cef_pkg::GATE_POWER_GOOD]    = src.power_good;
    ilvl[cef_pkg::GATE_INPUT_TWO]     = src.input_two_present;
    ilvl[cef_pkg::GATE_INPUT_ONE]     = src.input_one_present;
    ilvl[cef_pkg::GATE_BUS_PRESENT]   = src.bus_present;
    iprev_d = ilvl;
    // Rising edges for bits 7..4, any change for bits 3..0
    ievt = (ilvl & ~iprev_q)
         | (cef_pkg::GATE_BOTH & ~ilvl & iprev_q);
    // A gate bit of one suppresses its source
    irq_fire = |(ievt & ~gate_q);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      iprev_q <= cef_pkg::RESET_VAL;
    end else begin
      iprev_q <= iprev_d;
    end
  end

  // ****************************************************************
  // Interrupt pulse driver
  // ****************************************************************
  typedef enum logic [1:0] {
    CEF_IDLE  = 2'b01,
    CEF_PULSE = 2'b10
  } cef_state_t;

  cef_state_t  st_q;
  cef_state_t  st_d;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic        low_q;
  logic        low_d;

  // A new event during a pulse restarts it, so events merge rather
  // than producing back-to-back pulses the host could miss
  // A PULSE_CYCLES of zero wraps the count to a maximum-length pulse
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      CEF_IDLE: begin
        if (irq_fire) begin
          st_d  = CEF_PULSE;
          cnt_d = PULSE_CYCLES - 12'h001;
        end
      end
      CEF_PULSE: begin
        if (irq_fire) begin
          cnt_d = PULSE_CYCLES - 12'h001;
        end else if (cnt_q == 12'h000) begin
          st_d = CEF_IDLE;
        end else begin
          cnt_d = cnt_q - 12'h001;
        end
      end
      default: begin
        st_d  = CEF_IDLE;
        cnt_d = 12'h000;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= CEF_IDLE;
      cnt_q <= 12'h000;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************************
  // Wire level observed back
  // ****************************************************************
  // Wire is taken as synchronous; one register keeps the status steady
  always_comb begin
    low_d = !irq_out_n_in;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 1'b0;
    end else begin
      low_q <= low_d;
    end
  end

  // Pin only ever driven low; released otherwise
  assign irq_out_n_out  = 1'b0;
  assign irq_out_n_oe_n = (st_q != CEF_PULSE);
  assign irq_pin_low    = low_q;

endmodule

`default_nettype wire

// ---- bench/cef_checker.sv ----
// Port-level assertions for the charger event flag bank
`timescale 1ns/1ps
`default_nettype none
module cef_checker #(
  parameter logic [11:0] PULSE_CYCLES = cef_pkg::IRQ_PULSE_CYC
) (
  // Clock and resets
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              reg_reset_req,
  // Register port, sources and pin
  input wire cef_pkg::cef_req_t req,
  input wire logic [7:0]        rd_data,
  input wire logic              rd_valid,
  input wire cef_pkg::cef_src_t src,
  input wire logic              irq_out_n_out,
  input wire logic              irq_out_n_oe_n
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [11:0] low_q;
  // Counts low cycles so pulse width needs no long repetition;
  // saturates so a long merged pulse cannot wrap and look short
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 12'h000;
    end else if (irq_out_n_oe_n) begin
      low_q <= 12'h000;
    end else if (low_q != 12'hFFF) begin
      low_q <= low_q + 12'h001;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_rd_answer: assert property (req.rd |=> rd_valid)
    else $error("read not answered");
  a_rd_quiet: assert property (!req.rd |=> !rd_valid)
    else $error("stray read valid");
  a_rd_hold: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved");
  a_unmapped_zero: assert property (req.rd && !(req.addr inside
    {[8'h24:8'h28]}) |=> rd_data == cef_pkg::READ_NONE)
    else $error("unmapped read not zero");
  a_reserved_b: assert property (req.rd &&
    req.addr == cef_pkg::ADDR_LATCH_B |=> (rd_data & 8'h0B) == 8'h00)
    else $error("reserved bits set");
  a_reserved_d: assert property (req.rd &&
    req.addr == cef_pkg::ADDR_LATCH_D |=> (rd_data & 8'hE0) == 8'h00)
    else $error("reserved bits set");
  a_gate_regrst: assert property (reg_reset_req ##1 reg_reset_req &&
    req.rd && req.addr == cef_pkg::ADDR_GATE_A
    |=> rd_data == cef_pkg::RESET_VAL)
    else $error("gate survived register reset");
  a_pulse_cause: assert property ($fell(irq_out_n_oe_n) |->
    $past(src) != $past(src, 2))
    else $error("pulse without source change");
  a_pulse_width: assert property ($rose(irq_out_n_oe_n) |->
    low_q >= PULSE_CYCLES)
    else $error("pulse too short");
  a_pin_level: assert property (irq_out_n_out == 1'b0)
    else $error("pin drives high");
  c_pulse: cover property ($fell(irq_out_n_oe_n));
  c_flag_read: cover property (rd_valid && rd_data != 8'h00);
  c_regrst_wr: cover property (reg_reset_req && req.wr);
endmodule

bind cef_flag_bank cef_checker #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (
  .clock(clock), .rst_n(rst_n), .reg_reset_req(reg_reset_req),
  .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .src(src),
  .irq_out_n_out(irq_out_n_out), .irq_out_n_oe_n(irq_out_n_oe_n)
);
`default_nettype wire

// ---- bench/cef_host_model.sv ----
// Host-side model of the open-drain interrupt wire and its pull-up
`timescale 1ns/1ps
`default_nettype none
module cef_host_model (
  // Pin from the device
  input  wire logic irq_out_n_out,
  input  wire logic irq_out_n_oe_n,
  // Resolved wire and pulse count seen by the host
  output logic      irq_wire,
  output int        pulses
);
  int pulse_cnt = 0;
  // Pull-up holds the wire high whenever the device lets go
  assign irq_wire = irq_out_n_oe_n ? 1'b1 : irq_out_n_out;
  // Each falling edge is one interrupt to the host
  always @(negedge irq_wire) begin
    pulse_cnt++;
  end
  // Single driver for the count seen outside
  assign pulses = pulse_cnt;
endmodule
`default_nettype wire

// ---- bench/tb_charger_event_flag_and_mask_bank.sv ----
// Self-checking bench for the charger event flag bank
`timescale 1ns/1ps
`default_nettype none
module tb_charger_event_flag_and_mask_bank;
  localparam logic [11:0] PW = 12'h004;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              reg_rst = 1'b0;
  logic              osm = 1'b1;
  cef_pkg::cef_req_t req = '0;
  cef_pkg::cef_det_t det = '0;
  cef_pkg::cef_src_t src = '0;
  logic [7:0]        rd_data;
  logic              rd_valid;
  logic              out_v;
  logic              oe_n;
  logic              wire_v;
  logic              pin_low;
  int                pulses;
  int                fail_count = 0;
  int                n_checks = 0;

  // 40 MHz clock
  always #12.5 clock = ~clock;

  cef_flag_bank #(.PULSE_CYCLES(PW)) i_dut (
    .clock(clock), .rst_n(rst_n), .reg_reset_req(reg_rst), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .det(det),
    .one_shot_mode(osm), .src(src), .irq_out_n_in(wire_v),
    .irq_out_n_out(out_v), .irq_out_n_oe_n(oe_n), .irq_pin_low(pin_low)
  );
  cef_host_model i_host (
    .irq_out_n_out(out_v), .irq_out_n_oe_n(oe_n), .irq_wire(wire_v),
    .pulses(pulses)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chkn(string nm, int e, int g);
    n_checks++;
    if (g != e) begin
      fail_count++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask
  // Read strobe lasts one cycle; answer is settled at the next fall
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    @(negedge clock);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clock);
    req.rd = 1'b0;
    chk8("rd_valid", 8'h01, {7'h00, rd_valid});
    chk8($sformatf("reg %h", a), e, rd_data);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge clock);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(negedge clock);
    req.wr = 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      rdc(8'h24 + i[7:0], cef_pkg::RESET_VAL);
    end
    rdc(8'h29, cef_pkg::READ_NONE);
    wr(cef_pkg::ADDR_LATCH_A, 8'hFF);
    rdc(cef_pkg::ADDR_LATCH_A, 8'h00);
    osm = 1'b0;
    det.conversion_done = 1'b1;
    repeat (3) @(negedge clock);
    rdc(cef_pkg::ADDR_LATCH_C, 8'h00);
    det.conversion_done = 1'b0;
    osm = 1'b1;
    $display("test reset done");
  endtask
  // Every detector raised and lowered; both-edge bits relatch on fall
  task automatic t_flags();
    int         x;
    int         b;
    logic [7:0] a;
    logic [7:0] m;
    logic       both;
    for (int i = 0; i < 25; i++) begin
      x = i >= 18 ? 0 : i >= 13 ? 1 : i >= 5 ? 2 : 3;
      b = i >= 18 ? i - 18 : i >= 13 ? i - 13 : i >= 5 ? i - 5 : i + 3;
      b = i == 0 ? 2 : b;
      a = cef_pkg::LATCH_ADDR[x];
      m = 8'h01 << b;
      both = i == 22 || (i >= 12 && i <= 16);
      det[i] = 1'b1;
      repeat (2) @(negedge clock);
      rdc(a, m);
      rdc(a, 8'h00);
      det[i] = 1'b0;
      repeat (2) @(negedge clock);
      rdc(a, both ? m : 8'h00);
      rdc(a, 8'h00);
    end
    $display("test flags done");
  endtask
  // Each gate bit: two unmasked passes, one masked pass
  task automatic t_irq();
    int   sb;
    int   n;
    logic msk;
    for (int k = 0; k < 8; k++) begin
      for (int m = 0; m < 3; m++) begin
        msk = m == 2;
        sb = k < 6 ? k : 2 * k - 5 - m % 2;
        wr(cef_pkg::ADDR_GATE_A, msk ? 8'h01 << k : 8'h00);
        n = pulses;
        src[sb] = 1'b1;
        // Wire seen low one cycle after the pulse starts
        repeat (2) @(negedge clock);
        chk8("pin low", {7'h00, !msk}, {7'h00, pin_low});
        repeat (PW + 2) @(negedge clock);
        chk8("pin idle", 8'h00, {7'h00, pin_low});
        chkn("rise pulses", n + (msk ? 0 : 1), pulses);
        n = pulses;
        src[sb] = 1'b0;
        repeat (PW + 4) @(negedge clock);
        chkn("fall pulses", n + (!msk && k < 4), pulses);
      end
    end
    $display("test irq done");
  endtask
  task automatic t_regrst();
    wr(cef_pkg::ADDR_GATE_A, 8'hFF);
    rdc(cef_pkg::ADDR_GATE_A, 8'hFF);
    reg_rst = 1'b1;
    wr(cef_pkg::ADDR_GATE_A, 8'h5A);
    rdc(cef_pkg::ADDR_GATE_A, 8'h00);
    reg_rst = 1'b0;
    rdc(cef_pkg::ADDR_GATE_A, 8'h00);
    $display("test register reset done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_flags();
    t_irq();
    t_regrst();
    end_sim();
  end
  // Tests need about 770 cycles; generous margin before giving up
  initial begin
    repeat (40000) @(posedge clock);
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
